// ### design/scic_pkg.sv
// shared constants, types and the supply decode function of the smart-card interface control
package scic_pkg;

  // timing
  localparam int unsigned CLK_FREQ_KHZ  = 50000;
  localparam int unsigned DEBOUNCE_MS   = 8;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_FREQ_KHZ;
  localparam int unsigned SEQ_STEP_US   = 20;
  localparam int unsigned SEQ_STEP_CYC  = (SEQ_STEP_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int unsigned SEQ_W         = 12;

  // register map
  localparam int unsigned AXI_AW        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  localparam int unsigned CTRL_W        = 2;
  localparam int unsigned CTRL_CARD_PRESENT_IN_HI  = 0;
  localparam int unsigned CTRL_AUX_EN   = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h2;

  localparam int unsigned IRQ_W         = 5;
  localparam int unsigned IRQ_CARD_PRESENT_IN      = 0;
  localparam int unsigned IRQ_OCP       = 1;
  localparam int unsigned IRQ_OTP       = 2;
  localparam int unsigned IRQ_UVP       = 3;
  localparam int unsigned IRQ_AUTO      = 4;
  localparam logic [4:0]  IRQ_MASK_RST  = 5'h1F;
  localparam int unsigned STATUS_W      = 10;

  // synchroniser lanes
  localparam int unsigned NLINES        = 3;
  localparam int unsigned SY_ACT        = 0;
  localparam int unsigned SY_RST        = 1;
  localparam int unsigned SY_RSA        = 2;
  localparam int unsigned SY_RSB        = 3;
  localparam int unsigned SY_RANGE      = 4;
  localparam int unsigned SY_LEVEL      = 5;
  localparam int unsigned SY_CARD_PRESENT_IN_N     = 6;
  localparam int unsigned SY_CARD_PRESENT_IN       = 7;
  localparam int unsigned SY_OCP        = 8;
  localparam int unsigned SY_OTP        = 9;
  localparam int unsigned SY_UVP        = 10;
  localparam int unsigned SY_HOST       = 11;
  localparam int unsigned SY_CARD       = SY_HOST + NLINES;
  localparam int unsigned NSYNC         = SY_CARD + NLINES;

  typedef enum logic [1:0] {
    SUP_OFF = 2'h0,
    SUP_1V8 = 2'h1,
    SUP_3V  = 2'h2,
    SUP_5V  = 2'h3
  } scic_supply_e;

  typedef enum logic [3:0] {
    S_IDLE, S_PWR, S_IO, S_CLK, S_RUN, S_D_RST, S_D_CLK, S_D_IO, S_D_PWR
  } scic_state_e;

  typedef enum logic [2:0] {
    OWN_FREE, OWN_HOST, OWN_CARD, OWN_HOST_REL, OWN_CARD_REL
  } scic_own_e;

  function automatic scic_supply_e scic_supply_decode(input logic range_sel,
                                                      input logic level_sel);
    if (!range_sel)
      return level_sel ? SUP_5V : SUP_3V;
    return level_sel ? SUP_1V8 : SUP_3V;
  endfunction

endpackage

// ### design/scic_debounce.sv
// insertion debounce for the card presence level
`timescale 1ns/1ps
module scic_debounce
  import scic_pkg::*;
#(
  parameter int unsigned CYC = DEBOUNCE_CYC
) (
  input  wire logic aclk,     // system clock
  input  wire logic aresetn,  // sync reset, active low
  input  wire logic raw,      // synchronised presence, high = present
  output logic      stable    // debounced presence
);
  localparam int unsigned W = $clog2(CYC + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         stable;
  } scic_deb_s;

  scic_deb_s s_q;
  scic_deb_s s_d;

  always_comb begin
    s_d = s_q;
    // removal drops at once so deactivation of a pulled card starts without delay
    if (!raw) begin
      s_d.cnt    = '0;
      s_d.stable = 1'b0;
    end else if (!s_q.stable) begin
      if (s_q.cnt == W'(CYC - 1)) begin
        s_d.stable = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stable = s_q.stable;
endmodule

// ### design/scic_clkdiv.sv
// card clock divider fed by the sampled host clock
`timescale 1ns/1ps
module scic_clkdiv
  import scic_pkg::*;
(
  input  wire logic       aclk,           // system clock
  input  wire logic       aresetn,        // sync reset, active low
  input  wire logic       host_clock_in,  // host clock pin, asynchronous
  input  wire logic [1:0] ratio_sel,      // 0:1/1 1:1/2 2:1/4 3:1/8
  input  wire logic       run,            // clock wanted on the card
  output logic            card_clock_out  // divided card clock
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic [1:0] cnt;
    logic [1:0] ratio;
    logic       on;
    logic       clk;
  } scic_div_s;

  scic_div_s s_q;
  scic_div_s s_d;

  function automatic logic [1:0] half_last(input logic [1:0] r);
    case (r)
      2'h1:    return 2'h0;
      2'h2:    return 2'h1;
      default: return 2'h3;
    endcase
  endfunction

  logic rise;
  logic boundary;

  always_comb begin
    s_d      = s_q;
    s_d.s1   = host_clock_in;
    s_d.s2   = s_q.s1;
    s_d.s3   = s_q.s2;
    rise     = s_q.s2 & ~s_q.s3;
    // ratio and gating change only where a low phase ends, so no runt pulse
    boundary = rise & ~s_q.clk & ((s_q.ratio == 2'h0) | (s_q.cnt == half_last(s_q.ratio)));
    if (boundary) begin
      s_d.ratio = ratio_sel;
      s_d.on    = run;
      s_d.cnt   = 2'h0;
      s_d.clk   = run;
    end else if (s_q.ratio == 2'h0) begin
      s_d.clk = s_q.on & s_q.s2;
    end else if (rise) begin
      if (s_q.cnt == half_last(s_q.ratio)) begin
        s_d.cnt = 2'h0;
        s_d.clk = s_q.on & ~s_q.clk;
      end else begin
        s_d.cnt = s_q.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign card_clock_out = s_q.clk;
endmodule

// ### design/scic_top.sv
// smart-card interface control: sequencer, line forwarding, faults and AXI4-Lite registers
//
// Contract
// - range low: level high 5 V, else 3 V
// - range high: level high 1.8 V, else 3 V
// - active-low presence input: low means present
// - active-high presence input: high means present
// - debounce insertion about 8 ms
// - card clock divided 1/1, 1/2, 1/4, 1/8
// - card clock pin carries divided host clock
// - card reset follows host reset
// - serial io forwarded both ways, idles high
// - two aux lines forwarded both ways, idle high
// - auto deactivation on overload, heat, removal, dropout
// - interrupt for presence changes and faults
// - sequencer orders activation and deactivation steps
// - falling command with card present starts activation
// - interrupt low on presence or overload
`timescale 1ns/1ps
module scic_top
  import scic_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input  wire logic              aclk,                 // system clock
  input  wire logic              aresetn,              // sync reset, active low
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,         // write address
  input  wire logic              s_axi_awvalid,        // write address valid
  output logic                   s_axi_awready,        // write address ready
  input  wire logic [31:0]       s_axi_wdata,          // write data
  input  wire logic [3:0]        s_axi_wstrb,          // write byte strobes
  input  wire logic              s_axi_wvalid,         // write data valid
  output logic                   s_axi_wready,         // write data ready
  output logic [1:0]             s_axi_bresp,          // write response
  output logic                   s_axi_bvalid,         // write response valid
  input  wire logic              s_axi_bready,         // write response ready
  input  wire logic [AXI_AW-1:0] s_axi_araddr,         // read address
  input  wire logic              s_axi_arvalid,        // read address valid
  output logic                   s_axi_arready,        // read address ready
  output logic [31:0]            s_axi_rdata,          // read data
  output logic [1:0]             s_axi_rresp,          // read response
  output logic                   s_axi_rvalid,         // read data valid
  input  wire logic              s_axi_rready,         // read data ready
  input  wire logic              supply_range_select,  // supply range pin
  input  wire logic              supply_level_select,  // supply level pin
  input  wire logic              card_present_n_in,    // presence, low = present
  input  wire logic              card_present_in,      // presence, high = present
  input  wire logic              host_clock_in,        // host clock pin
  input  wire logic              clock_ratio_sel_a,    // ratio select, lsb
  input  wire logic              clock_ratio_sel_b,    // ratio select, msb
  input  wire logic              host_reset_in,        // host reset pin
  input  wire logic              activate_cmd_n,       // activation command, low = on
  input  wire logic              overcurrent_fault,    // supply overload flag
  input  wire logic              overtemp_fault,       // overtemperature flag
  input  wire logic              undervoltage_fault,   // supply dropout flag
  input  wire logic              host_io_i,            // host io level
  output logic                   host_io_o,            // host io drive value
  output logic                   host_io_oe,           // host io drive enable
  input  wire logic              host_aux_a_i,         // host aux a level
  output logic                   host_aux_a_o,         // host aux a drive value
  output logic                   host_aux_a_oe,        // host aux a drive enable
  input  wire logic              host_aux_b_i,         // host aux b level
  output logic                   host_aux_b_o,         // host aux b drive value
  output logic                   host_aux_b_oe,        // host aux b drive enable
  input  wire logic              card_serial_io_i,     // card io level
  output logic                   card_serial_io_o,     // card io drive value
  output logic                   card_serial_io_oe,    // card io drive enable
  input  wire logic              card_aux_line_a_i,    // card aux a level
  output logic                   card_aux_line_a_o,    // card aux a drive value
  output logic                   card_aux_line_a_oe,   // card aux a drive enable
  input  wire logic              card_aux_line_b_i,    // card aux b level
  output logic                   card_aux_line_b_o,    // card aux b drive value
  output logic                   card_aux_line_b_oe,   // card aux b drive enable
  output logic                   card_clock_out,       // card clock
  output logic                   card_reset_out,       // card reset
  output logic [1:0]             card_supply,          // supply level code, 0 = off
  output logic                   host_irq_n            // interrupt, active low
);
  typedef struct packed {
    logic [NSYNC-1:0]  sync1;
    logic [NSYNC-1:0]  sync2;
    logic              act_prev;
    logic              card_present_in_prev;
    logic [2:0]        fault_prev;
    scic_state_e       state;
    logic [SEQ_W-1:0]  timer;
    scic_supply_e      level;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    scic_own_e [NLINES-1:0] own;
    logic              rst_out;
    logic              aw_got;
    logic [AXI_AW-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } scic_top_s;

  scic_top_s s_q;
  scic_top_s s_d;

  logic              present;
  logic              supply_on;
  logic              io_on;
  logic              clk_on;
  logic [2:0]        fault_now;
  logic              fault_any;
  logic              deact;
  logic              act_fall;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  w1c;
  logic [NLINES-1:0] line_en;
  logic [NLINES-1:0] host_low;
  logic [NLINES-1:0] card_low;
  logic [STATUS_W-1:0] status;

  // sequencer phase decode shared by the outputs and the status word
  function automatic logic in_set(input scic_state_e st, input logic [8:0] mask);
    return mask[st];
  endfunction

  localparam logic [8:0] SET_SUPPLY = 9'h0FE;
  localparam logic [8:0] SET_IO     = 9'h07C;
  localparam logic [8:0] SET_CLK    = 9'h038;

  // synchronisers start at the pins' idle levels, so leaving reset raises no false event
  localparam logic [NSYNC-1:0] SYNC_IDLE =
    NSYNC'((((1 << (2 * NLINES)) - 1) << SY_HOST) | (1 << SY_CARD_PRESENT_IN_N) | (1 << SY_ACT));

  always_comb begin
    present  = 1'b0;
    present  = s_q.ctrl[CTRL_CARD_PRESENT_IN_HI] ? s_q.sync2[SY_CARD_PRESENT_IN]
                                      : ~s_q.sync2[SY_CARD_PRESENT_IN_N];
  end

  logic card_present_in_deb;

  scic_debounce #(
    .CYC (DEBOUNCE_CYCLES)
  ) u_debounce (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (present),
    .stable  (card_present_in_deb)
  );

  scic_clkdiv u_clkdiv (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .host_clock_in  (host_clock_in),
    .ratio_sel      ({s_q.sync2[SY_RSB], s_q.sync2[SY_RSA]}),
    .run            (clk_on),
    .card_clock_out (card_clock_out)
  );

  assign supply_on = in_set(s_q.state, SET_SUPPLY);
  assign io_on     = in_set(s_q.state, SET_IO);
  assign clk_on    = in_set(s_q.state, SET_CLK);
  assign fault_now = {s_q.sync2[SY_UVP], s_q.sync2[SY_OTP], s_q.sync2[SY_OCP]};
  assign fault_any = |fault_now;
  assign act_fall  = s_q.act_prev & ~s_q.sync2[SY_ACT];
  assign deact     = s_q.sync2[SY_ACT] | fault_any | ~card_present_in_deb;
  assign status    = {fault_any, s_q.sync2[SY_RSB], s_q.sync2[SY_RSA], s_q.level,
                      s_q.rst_out, clk_on, io_on, supply_on, card_present_in_deb};

  always_comb begin
    for (int i = 0; i < NLINES; i++) begin
      host_low[i] = ~s_q.sync2[SY_HOST + i];
      card_low[i] = ~s_q.sync2[SY_CARD + i];
      line_en[i]  = io_on & ((i == 0) | s_q.ctrl[CTRL_AUX_EN]);
    end
  end

  always_comb begin
    s_d          = s_q;
    s_d.sync1    = {card_aux_line_b_i, card_aux_line_a_i, card_serial_io_i,
                    host_aux_b_i, host_aux_a_i, host_io_i,
                    undervoltage_fault, overtemp_fault, overcurrent_fault,
                    card_present_in, card_present_n_in,
                    supply_level_select, supply_range_select,
                    clock_ratio_sel_b, clock_ratio_sel_a,
                    host_reset_in, activate_cmd_n};
    s_d.sync2      = s_q.sync1;
    s_d.act_prev   = s_q.sync2[SY_ACT];
    s_d.card_present_in_prev  = card_present_in_deb;
    s_d.fault_prev = fault_now;
    ev             = '0;
    w1c            = '0;

    // events for the interrupt status
    ev[IRQ_CARD_PRESENT_IN] = card_present_in_deb ^ s_q.card_present_in_prev;
    ev[IRQ_OCP]  = fault_now[0] & ~s_q.fault_prev[0];
    ev[IRQ_OTP]  = fault_now[1] & ~s_q.fault_prev[1];
    ev[IRQ_UVP]  = fault_now[2] & ~s_q.fault_prev[2];

    // sequencer: each step waits one step time before the next
    unique case (s_q.state)
      S_IDLE: begin
        if (act_fall && card_present_in_deb && !fault_any) begin
          s_d.level = scic_supply_decode(s_q.sync2[SY_RANGE],
                                         s_q.sync2[SY_LEVEL]);
          s_d.state = S_PWR;
          s_d.timer = SEQ_W'(SEQ_STEP_CYC - 1);
        end
      end
      S_PWR, S_IO, S_CLK, S_RUN: begin
        if (deact) begin
          s_d.state = S_D_RST;
          s_d.timer = SEQ_W'(SEQ_STEP_CYC - 1);
          ev[IRQ_AUTO] = fault_any | ~card_present_in_deb;
        end else if (s_q.state != S_RUN) begin
          if (s_q.timer == '0) begin
            s_d.state = (s_q.state == S_PWR) ? S_IO :
                        (s_q.state == S_IO)  ? S_CLK : S_RUN;
            s_d.timer = SEQ_W'(SEQ_STEP_CYC - 1);
          end else begin
            s_d.timer = s_q.timer - SEQ_W'(1);
          end
        end
      end
      S_D_RST, S_D_CLK, S_D_IO, S_D_PWR: begin
        // a started deactivation always runs to the end
        if (s_q.timer == '0) begin
          s_d.state = (s_q.state == S_D_RST) ? S_D_CLK :
                      (s_q.state == S_D_CLK) ? S_D_IO  :
                      (s_q.state == S_D_IO)  ? S_D_PWR : S_IDLE;
          s_d.timer = SEQ_W'(SEQ_STEP_CYC - 1);
        end else begin
          s_d.timer = s_q.timer - SEQ_W'(1);
        end
      end
      default: begin
        s_d.state = S_IDLE;
      end
    endcase

    s_d.rst_out = (s_q.state == S_RUN) & ~deact & s_q.sync2[SY_RST];

    // line forwarding: first side to pull low owns the line until it lets go
    for (int i = 0; i < NLINES; i++) begin
      if (!line_en[i]) begin
        s_d.own[i] = OWN_HOST_REL;
      end else begin
        unique case (s_q.own[i])
          OWN_FREE: begin
            if (host_low[i]) begin
              s_d.own[i] = OWN_HOST;
            end else if (card_low[i]) begin
              s_d.own[i] = OWN_CARD;
            end
          end
          OWN_HOST: if (!host_low[i]) s_d.own[i] = OWN_HOST_REL;
          OWN_CARD: if (!card_low[i]) s_d.own[i] = OWN_CARD_REL;
          // wait for the pull-up on the far side, else our own drive echoes back
          OWN_HOST_REL: if (!card_low[i]) s_d.own[i] = OWN_FREE;
          OWN_CARD_REL: if (!host_low[i]) s_d.own[i] = OWN_FREE;
          default: s_d.own[i] = OWN_HOST_REL;
        endcase
      end
    end

    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case ({s_q.awaddr[AXI_AW-1:2], 2'h0})
        OFS_CTRL: if (s_q.wstrb[0]) s_d.ctrl = s_q.wdata[CTRL_W-1:0];
        OFS_STATUS: ;
        OFS_IRQ_STAT: if (s_q.wstrb[0]) w1c = s_q.wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: if (s_q.wstrb[0]) s_d.irq_mask = s_q.wdata[IRQ_W-1:0];
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    // a new event beats a clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;

    // AXI4-Lite read
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      unique case ({s_axi_araddr[AXI_AW-1:2], 2'h0})
        OFS_CTRL:     s_d.rdata = 32'(s_q.ctrl);
        OFS_STATUS:   s_d.rdata = 32'(status);
        OFS_IRQ_STAT: s_d.rdata = 32'(s_q.irq_stat);
        OFS_IRQ_MASK: s_d.rdata = 32'(s_q.irq_mask);
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.sync1    <= SYNC_IDLE;
      s_q.sync2    <= SYNC_IDLE;
      s_q.act_prev <= 1'b1;
      s_q.state    <= S_IDLE;
      s_q.level    <= SUP_OFF;
      s_q.ctrl     <= CTRL_RESET;
      s_q.irq_mask <= IRQ_MASK_RST;
      s_q.own      <= '{default: OWN_HOST_REL};
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_got & ~s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  assign host_irq_n     = ~|(s_q.irq_stat & s_q.irq_mask);
  assign card_reset_out = s_q.rst_out;
  assign card_supply    = supply_on ? s_q.level : SUP_OFF;

  // open-drain style: a side is only ever pulled low, pull-ups give the high
  assign card_serial_io_o   = 1'b0;
  assign card_aux_line_a_o  = 1'b0;
  assign card_aux_line_b_o  = 1'b0;
  assign host_io_o          = 1'b0;
  assign host_aux_a_o       = 1'b0;
  assign host_aux_b_o       = 1'b0;
  assign card_serial_io_oe  = (s_q.own[0] == OWN_HOST) | ~line_en[0];
  assign card_aux_line_a_oe = (s_q.own[1] == OWN_HOST) | ~line_en[1];
  assign card_aux_line_b_oe = (s_q.own[2] == OWN_HOST) | ~line_en[2];
  assign host_io_oe         = (s_q.own[0] == OWN_CARD);
  assign host_aux_a_oe      = (s_q.own[1] == OWN_CARD);
  assign host_aux_b_oe      = (s_q.own[2] == OWN_CARD);
endmodule

// ### tb/scic_card_model.sv
// card side of the three contact lines, each with a pull-up
`timescale 1ns/1ps
module scic_card_model (
  input  wire logic [2:0] dut_oe,   // design pulls low
  input  wire logic [2:0] card_low, // card pulls low
  output logic      [2:0] line      // resolved contact level
);
  // a released line rises through the pull-up
  assign line = ~(dut_oe | card_low);
endmodule

// ### tb/scic_top_props.sv
// port-level assertions for the smart-card interface control
`timescale 1ns/1ps
module scic_top_props (
  input wire logic       aclk,              // clock
  input wire logic       aresetn,           // reset, active low
  input wire logic [1:0] card_supply,       // supply code
  input wire logic       card_reset_out,    // card reset
  input wire logic       card_clock_out,    // card clock
  input wire logic       card_serial_io_oe, // card io pull
  input wire logic       card_serial_io_o,  // card io value
  input wire logic       host_io_o,         // host io value
  input wire logic       host_io_oe,        // host io pull
  input wire logic       overcurrent_fault  // overload flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SUP_RST: assert property ($rose(aresetn) |-> card_supply == 2'h0)
    else $error("supply on after reset");
  AST_SUP_CODE: assert property ($changed(card_supply) |->
    card_supply == 2'h0 || $past(card_supply) == 2'h0) else $error("supply level hopped");
  AST_CLK_SUP: assert property ($changed(card_clock_out) |-> card_supply != 2'h0)
    else $error("clock without supply");
  AST_RST_SUP: assert property (card_reset_out |-> card_supply != 2'h0)
    else $error("reset high without supply");
  AST_IO_OFF: assert property (card_supply == 2'h0 |-> card_serial_io_oe)
    else $error("io free without supply");
  AST_OPEN_DRAIN: assert property (!(card_serial_io_o || host_io_o ||
    (card_serial_io_oe && host_io_oe))) else $error("line driven high or from both sides");
  AST_FLT: assert property ($rose(overcurrent_fault) |-> ##[1:8] !card_reset_out)
    else $error("reset kept on overload");
  AST_IO_GAP: assert property ($rose(card_supply != 2'h0) |=> card_serial_io_oe [*8])
    else $error("io freed with supply");
  cover property ($rose(card_reset_out));
  cover property ($changed(card_clock_out));
  cover property ($fell(card_supply != 2'h0));
endmodule
bind scic_top scic_top_props i_props (.*);

// ### tb/smart_card_interface_control_test.sv
// self-checking bench for the smart-card interface control
`timescale 1ns/1ps
module smart_card_interface_control_test;
  import scic_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, card_supply, rr, br;
  logic s_axi_arvalid = 0, s_axi_rready = 0, supply_range_select = 0, supply_level_select = 0;
  logic card_present_n_in = 1, card_present_in = 0, host_clock_in = 0, host_reset_in = 0;
  logic clock_ratio_sel_a = 1, clock_ratio_sel_b = 1, activate_cmd_n = 1;
  logic overcurrent_fault = 0, overtemp_fault = 0, undervoltage_fault = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic host_io_o, host_io_oe, host_aux_a_o, host_aux_a_oe, host_aux_b_o, host_aux_b_oe;
  logic card_serial_io_o, card_serial_io_oe, card_aux_line_a_o, card_aux_line_a_oe;
  logic card_aux_line_b_o, card_aux_line_b_oe, card_clock_out, card_reset_out, host_irq_n;
  logic [2:0] h_low = 0, c_low = 0;
  wire host_io_i, host_aux_a_i, host_aux_b_i;
  wire card_serial_io_i, card_aux_line_a_i, card_aux_line_b_i;
  int miscompares = 0, total_checks = 0, cyc = 0;
  scic_top #(.DEBOUNCE_CYCLES(20)) i_dut (.*);
  scic_card_model i_card (
    .dut_oe  ({card_aux_line_b_oe, card_aux_line_a_oe, card_serial_io_oe}),
    .card_low(c_low),
    .line    ({card_aux_line_b_i, card_aux_line_a_i, card_serial_io_i})
  );
  // host lines resolve with the same pull-up as the card side
  assign {host_aux_b_i, host_aux_a_i, host_io_i} =
    ~({host_aux_b_oe, host_aux_a_oe, host_io_oe} | h_low);
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0) host_clock_in <= ~host_clock_in;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wsup(input logic on);
    int n = 0;
    while ((card_supply != 2'h0) !== on && n < 6000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      tick(1);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
    tick(1);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      tick(1);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    {rd, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
    tick(1);
  endtask
  task automatic t_reset();
    chk(card_supply, SUP_OFF);
    chk(host_irq_n, 1'h1);
    axr(OFS_IRQ_MASK);
    chk(rd, IRQ_MASK_RST);
    axr(8'h10);
    chk(rr, RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_supply();
    scic_supply_e exp_sup [4] = '{SUP_3V, SUP_5V, SUP_3V, SUP_1V8};
    card_present_n_in <= 1'h0;
    tick(40);
    for (int i = 0; i < 4; i++) begin
      {supply_range_select, supply_level_select} <= i[1:0];
      tick(4);
      activate_cmd_n <= 1'h0;
      wsup(1'h1);
      chk(card_supply, exp_sup[i]);
      activate_cmd_n <= 1'h1;
      wsup(1'h0);
      chk(card_serial_io_oe, 1'h1);
      tick(1100);
    end
    $display("supply test done");
  endtask
  task automatic t_run();
    time t0;
    host_reset_in <= 1'h1;
    activate_cmd_n <= 1'h0;
    tick(3100);
    chk(card_reset_out, 1'h1);
    chk(host_irq_n, 1'h0);
    h_low[0] <= 1'h1;
    tick(6);
    chk(card_serial_io_i, 1'h0);
    h_low[0] <= 1'h0;
    c_low[1] <= 1'h1;
    tick(6);
    chk(host_aux_a_i, 1'h0);
    c_low[1] <= 1'h0;
    // host clock period is 8 cycles, so ratio r gives a card period of 8 << r
    for (int r = 3; r >= 0; r--) begin
      {clock_ratio_sel_b, clock_ratio_sel_a} <= r[1:0];
      tick(150);
      @(posedge card_clock_out) t0 = $time;
      @(posedge card_clock_out) chk(32'(($time - t0) / 20), 8 << r);
    end
    $display("run test done");
  endtask
  task automatic t_fault();
    overcurrent_fault <= 1'h1;
    tick(8);
    chk(card_reset_out, 1'h0);
    wsup(1'h0);
    chk(card_supply, SUP_OFF);
    overcurrent_fault <= 1'h0;
    tick(1100);
    axr(OFS_IRQ_STAT);
    chk(rd, (1 << IRQ_CARD_PRESENT_IN) | (1 << IRQ_OCP) | (1 << IRQ_AUTO));
    axw(OFS_IRQ_STAT, 32'h1F);
    chk(br, RESP_OKAY);
    tick(2);
    chk(host_irq_n, 1'h1);
    axw(OFS_CTRL, 32'h3);
    tick(4);
    axr(OFS_STATUS);
    chk(rd[0], 1'h0);
    card_present_in <= 1'h1;
    tick(40);
    axr(OFS_STATUS);
    chk(rd[0], 1'h1);
    $display("fault test done");
  endtask
  initial begin
    tick(3);
    aresetn <= 1'h1;
    tick(1);
    t_reset();
    t_supply();
    t_run();
    t_fault();
    print_verdict();
  end
endmodule
